// *** dsss_params.svh ***
`ifndef DSSS_PARAMS_SVH
`define DSSS_PARAMS_SVH

// chip strobe divider floor: chip rate at most one quarter of the sample rate
`define DSSS_MIN_CHIP_DIV 8'h04
// longest code per symbol, in chips
`define DSSS_MAX_CODE_LEN 7'h40
// transmit data buffer
`define DSSS_FIFO_DEPTH 16
`define DSSS_FIFO_WIDTH 2
// transmit IF amplitude, signed full scale
`define DSSS_TX_AMP 9'h07F
// overlay generator seed and tap positions
`define DSSS_OVL_SEED 7'h7F
`define DSSS_OVL_TAP_A 6
`define DSSS_OVL_TAP_B 5

`endif

// *** dsss_pkg.sv ***
package dsss_pkg;
    typedef enum logic [1:0] {TX_IDLE, TX_PREAMBLE, TX_DATA} dsss_tx_state_type;
    typedef enum logic {RX_ACQUIRE, RX_DATA} dsss_rx_state_type;
endpackage

// *** dsss_fifo_if.sv ***
`timescale 1ns/10ps
interface dsss_fifo_if #(
    parameter int WIDTH = 2
);
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;
    modport owner (input in_valid, input in_data, input out_ready,
                   output in_ready, output out_valid, output out_data);
    modport user (output in_valid, output in_data, output out_ready,
                  input in_ready, input out_valid, input out_data);
endinterface

// *** dsss_fifo.sv ***
`timescale 1ns/10ps
`include "dsss_params.svh"
module dsss_fifo #(
    parameter int WIDTH = `DSSS_FIFO_WIDTH,
    parameter int DEPTH = `DSSS_FIFO_DEPTH
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    dsss_fifo_if.owner bus
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic push;
    logic load;

    assign push = bus.in_valid && bus.in_ready;
    // output register refills whenever memory holds data and it is empty or being drained
    assign load = (count != '0) && (!bus.out_valid || bus.out_ready);
    assign next_count = count + CW'(push) - CW'(load);

    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem[wr_ptr] <= bus.in_data;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            bus.in_ready <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (load) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= next_count;
            bus.in_ready <= next_count < DEPTH_C;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            bus.out_valid <= 1'b0;
            bus.out_data <= '0;
        end else if (load) begin
            bus.out_valid <= 1'b1;
            bus.out_data <= mem[rd_ptr];
        end else if (bus.out_ready) begin
            bus.out_valid <= 1'b0;
        end
    end

    a_fifo_bound: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        count <= DEPTH_C)
        else $error("fifo count above depth");
    a_fifo_no_overrun: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        count == DEPTH_C |-> !bus.in_ready)
        else $error("fifo ready while full");
endmodule

// *** dsss_core.sv ***
`timescale 1ns/10ps
`include "dsss_params.svh"
module dsss_core #(
    parameter int CODE_W = 64,
    parameter int ACC_W = 18
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] chip_div_i,
    input wire logic [6:0] acq_len_i,
    input wire logic [6:0] data_len_i,
    input wire logic [CODE_W-1:0] acq_code_i,
    input wire logic [CODE_W-1:0] data_code_i,
    input wire logic qpsk_mode_i,
    input wire logic overlay_en_i,
    input wire logic ext_mod_i,
    input wire logic tx_start_i,
    input wire logic [1:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    output logic tx_active_o,
    output logic tx_sym_o,
    output logic tx_chip_i_o,
    output logic tx_chip_q_o,
    output logic [7:0] tx_if_o,
    input wire logic [7:0] rx_i_i,
    input wire logic [7:0] rx_q_i,
    input wire logic [7:0] rx_thresh_i,
    input wire logic rx_restart_i,
    output logic rx_acq_o,
    output logic rx_sym_o,
    output logic [1:0] rx_data_o,
    output logic rx_valid_o
);
    function automatic logic [6:0] clamp_len(input logic [6:0] len);
        if (len == 7'h00) begin
            return 7'h01;
        end
        return (len > `DSSS_MAX_CODE_LEN) ? `DSSS_MAX_CODE_LEN : len;
    endfunction

    function automatic logic [6:0] ovl_step(input logic [6:0] s);
        return {s[5:0], s[`DSSS_OVL_TAP_A] ^ s[`DSSS_OVL_TAP_B]};
    endfunction

    dsss_fifo_if #(.WIDTH(`DSSS_FIFO_WIDTH)) fifo_bus ();

    dsss_fifo #(.WIDTH(`DSSS_FIFO_WIDTH), .DEPTH(`DSSS_FIFO_DEPTH)) u_fifo (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .bus(fifo_bus.owner)
    );

    assign fifo_bus.in_valid = tx_valid_i;
    assign fifo_bus.in_data = tx_data_i;
    assign tx_ready_o = fifo_bus.in_ready;

    // ------------------------------------------------------------
    // chip strobe
    // ------------------------------------------------------------
    logic [7:0] eff_div;
    logic [7:0] div_cnt;
    logic chip_stb;
    logic [6:0] alen;
    logic [6:0] dlen;

    assign eff_div = (chip_div_i < `DSSS_MIN_CHIP_DIV) ? `DSSS_MIN_CHIP_DIV : chip_div_i;
    assign alen = clamp_len(acq_len_i);
    assign dlen = clamp_len(data_len_i);

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            div_cnt <= 8'h00;
            chip_stb <= 1'b0;
        end else if (div_cnt >= eff_div - 8'h01) begin
            div_cnt <= 8'h00;
            chip_stb <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 8'h01;
            chip_stb <= 1'b0;
        end
    end

    a_chip_div_min: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        chip_stb |=> !chip_stb [*3])
        else $error("chip strobes closer than four clocks");

    // ------------------------------------------------------------
    // transmit sequencing and differential encoding
    // ------------------------------------------------------------
    dsss_pkg::dsss_tx_state_type tx_state;
    logic [6:0] tx_idx;
    logic [1:0] tx_enc;
    logic [1:0] tx_phase;
    logic [6:0] tx_lfsr;
    logic tx_busy;
    logic tx_last;
    logic tx_code_bit;
    logic [1:0] tx_inc;
    logic [1:0] next_enc;
    logic tx_pop;

    assign tx_busy = tx_state != dsss_pkg::TX_IDLE;
    assign tx_last = tx_idx == ((tx_state == dsss_pkg::TX_PREAMBLE) ? alen : dlen) - 7'h01;
    assign tx_code_bit = (tx_state == dsss_pkg::TX_PREAMBLE) ? acq_code_i[tx_idx[5:0]] : data_code_i[tx_idx[5:0]];
    assign tx_inc = qpsk_mode_i ? fifo_bus.out_data : {fifo_bus.out_data[0], 1'b0};
    assign next_enc = tx_enc + tx_inc;
    assign tx_pop = tx_busy && chip_stb && tx_last && fifo_bus.out_valid;
    assign fifo_bus.out_ready = tx_pop;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            tx_state <= dsss_pkg::TX_IDLE;
            tx_idx <= 7'h00;
            tx_enc <= 2'h0;
            tx_phase <= 2'h0;
            tx_lfsr <= `DSSS_OVL_SEED;
        end else begin
            case (tx_state)
                dsss_pkg::TX_IDLE: begin
                    if (tx_start_i) begin
                        tx_state <= dsss_pkg::TX_PREAMBLE;
                        tx_idx <= 7'h00;
                        tx_enc <= 2'h0;
                        tx_phase <= 2'h0;
                        tx_lfsr <= `DSSS_OVL_SEED;
                    end
                end
                dsss_pkg::TX_PREAMBLE, dsss_pkg::TX_DATA: begin
                    if (chip_stb && tx_last) begin
                        tx_idx <= 7'h00;
                        if (fifo_bus.out_valid) begin
                            tx_state <= dsss_pkg::TX_DATA;
                            tx_enc <= next_enc;
                            tx_phase <= next_enc + {overlay_en_i & tx_lfsr[6], 1'b0};
                            tx_lfsr <= ovl_step(tx_lfsr);
                        end else begin
                            tx_state <= dsss_pkg::TX_IDLE;
                        end
                    end else if (chip_stb) begin
                        tx_idx <= tx_idx + 7'h01;
                    end
                end
                default: begin
                    tx_state <= dsss_pkg::TX_IDLE;
                end
            endcase
        end
    end

    a_tx_diff_enc: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        tx_pop && qpsk_mode_i |=> tx_enc == $past(tx_enc) + $past(fifo_bus.out_data))
        else $error("qpsk symbol phase step wrong");

    // ------------------------------------------------------------
    // chip outputs and IF modulator
    // ------------------------------------------------------------
    logic [1:0] car_k;
    logic [8:0] lvl_i;
    logic [8:0] lvl_q;

    assign lvl_i = tx_chip_i_o ? -`DSSS_TX_AMP : `DSSS_TX_AMP;
    assign lvl_q = tx_chip_q_o ? -`DSSS_TX_AMP : `DSSS_TX_AMP;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            tx_chip_i_o <= 1'b0;
            tx_chip_q_o <= 1'b0;
            tx_sym_o <= 1'b0;
            tx_active_o <= 1'b0;
        end else begin
            tx_active_o <= tx_busy;
            tx_sym_o <= tx_busy && chip_stb && tx_last;
            if (chip_stb) begin
                // a set bit is a negative level; the code bit flips both rails
                tx_chip_i_o <= tx_busy && ((tx_phase == 2'h1 || tx_phase == 2'h2) ^ tx_code_bit);
                tx_chip_q_o <= tx_busy && (tx_phase[1] ^ tx_code_bit);
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            car_k <= 2'h0;
            tx_if_o <= 8'h00;
        end else begin
            car_k <= car_k + 2'h1;
            if (ext_mod_i || !tx_active_o) begin
                tx_if_o <= 8'h00;
            end else begin
                case (car_k)
                    2'h0: tx_if_o <= lvl_i[7:0];
                    2'h1: tx_if_o <= 8'(-lvl_q);
                    2'h2: tx_if_o <= 8'(-lvl_i);
                    default: tx_if_o <= lvl_q[7:0];
                endcase
            end
        end
    end

    a_ext_mod_quiet: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ext_mod_i |=> tx_if_o == 8'h00)
        else $error("IF output active with external modulator");
    a_tx_sym_align: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        tx_busy && chip_stb && tx_last |=> tx_sym_o && tx_idx == 7'h00)
        else $error("symbol strobe not at code wrap");

    // ------------------------------------------------------------
    // receive downconversion and chip integration
    // ------------------------------------------------------------
    logic signed [8:0] mix_i;
    logic signed [8:0] mix_q;
    logic signed [ACC_W-1:0] acc_i;
    logic signed [ACC_W-1:0] acc_q;
    logic [CODE_W-1:0] sr_i;
    logic [CODE_W-1:0] sr_q;
    logic eval;

    always_comb begin
        case (car_k)
            2'h0: begin
                mix_i = $signed({rx_i_i[7], rx_i_i});
                mix_q = $signed({rx_q_i[7], rx_q_i});
            end
            2'h1: begin
                mix_i = $signed({rx_q_i[7], rx_q_i});
                mix_q = -$signed({rx_i_i[7], rx_i_i});
            end
            2'h2: begin
                mix_i = -$signed({rx_i_i[7], rx_i_i});
                mix_q = -$signed({rx_q_i[7], rx_q_i});
            end
            default: begin
                mix_i = -$signed({rx_q_i[7], rx_q_i});
                mix_q = $signed({rx_i_i[7], rx_i_i});
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            acc_i <= '0;
            acc_q <= '0;
            sr_i <= '0;
            sr_q <= '0;
            eval <= 1'b0;
        end else begin
            eval <= chip_stb;
            if (chip_stb) begin
                sr_i <= {sr_i[CODE_W-2:0], acc_i[ACC_W-1]};
                sr_q <= {sr_q[CODE_W-2:0], acc_q[ACC_W-1]};
                acc_i <= ACC_W'(mix_i);
                acc_q <= ACC_W'(mix_q);
            end else begin
                acc_i <= acc_i + ACC_W'(mix_i);
                acc_q <= acc_q + ACC_W'(mix_q);
            end
        end
    end

    // ------------------------------------------------------------
    // matched filter with two code sets
    // ------------------------------------------------------------
    dsss_pkg::dsss_rx_state_type rx_state;
    logic [6:0] rx_len;
    logic [CODE_W-1:0] rx_code;
    logic [CODE_W-1:0] hit_i;
    logic [CODE_W-1:0] hit_q;
    logic [6:0] cnt_i;
    logic [6:0] cnt_q;
    logic signed [8:0] corr_i;
    logic signed [8:0] corr_q;
    logic [9:0] mag;
    logic detect;
    logic [1:0] rx_p;

    assign rx_len = (rx_state == dsss_pkg::RX_ACQUIRE) ? alen : dlen;
    assign rx_code = (rx_state == dsss_pkg::RX_ACQUIRE) ? acq_code_i : data_code_i;

    for (genvar k = 0; k < CODE_W; k++) begin : g_tap
        logic [6:0] ref_idx;
        assign ref_idx = rx_len - 7'(k) - 7'h01;
        // oldest chip in the window lines up with code chip zero
        assign hit_i[k] = (7'(k) < rx_len) && !(sr_i[k] ^ rx_code[ref_idx[5:0]]);
        assign hit_q[k] = (7'(k) < rx_len) && !(sr_q[k] ^ rx_code[ref_idx[5:0]]);
    end

    always_comb begin
        cnt_i = 7'h00;
        cnt_q = 7'h00;
        for (int k = 0; k < CODE_W; k++) begin
            cnt_i = cnt_i + 7'(hit_i[k]);
            cnt_q = cnt_q + 7'(hit_q[k]);
        end
    end

    assign corr_i = $signed({1'b0, cnt_i, 1'b0}) - $signed({2'b00, rx_len});
    assign corr_q = $signed({1'b0, cnt_q, 1'b0}) - $signed({2'b00, rx_len});
    assign mag = 10'(corr_i[8] ? -corr_i : corr_i) + 10'(corr_q[8] ? -corr_q : corr_q);
    assign detect = mag >= {2'b00, rx_thresh_i};
    assign rx_p = {corr_q[8], corr_i[8] ^ corr_q[8]};

    // ------------------------------------------------------------
    // symbol timing and differential demodulation
    // ------------------------------------------------------------
    logic [6:0] rx_cnt;
    logic [1:0] rx_prev;
    logic [6:0] rx_lfsr;
    logic rx_end;
    logic [1:0] rx_q;
    logic [1:0] rx_d;

    assign rx_end = rx_state == dsss_pkg::RX_DATA && eval && rx_cnt == dlen - 7'h01;
    assign rx_q = rx_p - {overlay_en_i & rx_lfsr[6], 1'b0};
    assign rx_d = rx_q - rx_prev;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || rx_restart_i) begin
            rx_state <= dsss_pkg::RX_ACQUIRE;
            rx_cnt <= 7'h00;
            rx_prev <= 2'h0;
            rx_lfsr <= `DSSS_OVL_SEED;
        end else begin
            case (rx_state)
                dsss_pkg::RX_ACQUIRE: begin
                    if (eval && detect) begin
                        rx_state <= dsss_pkg::RX_DATA;
                        rx_cnt <= 7'h00;
                        rx_prev <= rx_p;
                        rx_lfsr <= `DSSS_OVL_SEED;
                    end
                end
                dsss_pkg::RX_DATA: begin
                    if (rx_end) begin
                        rx_cnt <= 7'h00;
                        rx_prev <= rx_q;
                        rx_lfsr <= ovl_step(rx_lfsr);
                    end else if (eval) begin
                        rx_cnt <= rx_cnt + 7'h01;
                    end
                end
                default: begin
                    rx_state <= dsss_pkg::RX_ACQUIRE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            rx_acq_o <= 1'b0;
            rx_sym_o <= 1'b0;
            rx_valid_o <= 1'b0;
            rx_data_o <= 2'h0;
        end else begin
            rx_acq_o <= !rx_restart_i && (rx_state == dsss_pkg::RX_DATA || (eval && detect));
            rx_sym_o <= !rx_restart_i && (rx_end || (rx_state == dsss_pkg::RX_ACQUIRE && eval && detect));
            rx_valid_o <= !rx_restart_i && rx_end;
            if (rx_end) begin
                rx_data_o <= qpsk_mode_i ? rx_d : {1'b0, rx_d[1]};
            end
        end
    end

    a_acq_switch: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        rx_state == dsss_pkg::RX_ACQUIRE && eval && detect && !rx_restart_i |=> rx_state == dsss_pkg::RX_DATA)
        else $error("no switch to data code on acquisition");
    a_bpsk_one_bit: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        rx_valid_o && !$past(qpsk_mode_i) |-> rx_data_o[1] == 1'b0)
        else $error("bpsk symbol carried more than one bit");
    a_rx_sym_period: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        rx_end && !rx_restart_i |=> rx_sym_o && rx_valid_o && rx_cnt == 7'h00)
        else $error("receive symbol strobe missing at code wrap");
endmodule

// *** dsss_link_model.sv ***
`timescale 1ns/10ps
module dsss_link_model (
    input wire logic sys_clk_i,
    input wire logic active_i,
    input wire logic chip_i_i,
    input wire logic chip_q_i,
    output logic [7:0] rx_i_o,
    output logic [7:0] rx_q_o
);
    logic flip;
    logic [1:0] k;
    logic [7:0] bi;
    logic [7:0] bq;

    initial begin
        flip = 1'b0;
        k = 2'h0;
    end

    // --------------------------------
    // modulator plus converters, one sample per clock, toggling when silent
    // --------------------------------
    always @(posedge sys_clk_i) begin
        flip <= ~flip;
        k <= k + 2'h1;
    end

    // baseband lifted onto a quarter-rate carrier, converters without delay
    always_comb begin
        bi = (active_i ? chip_i_i : flip) ? 8'hC0 : 8'h40;
        bq = (active_i ? chip_q_i : ~flip) ? 8'hC0 : 8'h40;
        case (k)
            2'h0: begin
                rx_i_o = bi;
                rx_q_o = bq;
            end
            2'h1: begin
                rx_i_o = -bq;
                rx_q_o = bi;
            end
            2'h2: begin
                rx_i_o = -bi;
                rx_q_o = -bq;
            end
            default: begin
                rx_i_o = bq;
                rx_q_o = -bi;
            end
        endcase
    end
endmodule

// *** test_dsss_symbol_sync_pn_core.sv ***
`timescale 1ns/10ps
module test_dsss_symbol_sync_pn_core;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] chip_div_i = 8'h04;
    logic [6:0] acq_len_i = 7'h0D;
    logic [6:0] data_len_i = 7'h0B;
    logic [63:0] acq_code_i = 64'h0000_0000_0000_0A60;
    logic [63:0] data_code_i = 64'h0000_0000_0000_05B8;
    logic qpsk_mode_i = 1'b1;
    logic overlay_en_i = 1'b0;
    logic ext_mod_i = 1'b0;
    logic tx_start_i = 1'b0;
    logic [1:0] tx_data_i = 2'h0;
    logic tx_valid_i = 1'b0;
    logic [7:0] rx_thresh_i = 8'h18;
    logic rx_restart_i = 1'b0;
    logic tx_ready_o, tx_active_o, tx_sym_o, tx_chip_i_o, tx_chip_q_o;
    logic [7:0] tx_if_o, rx_i_i, rx_q_i;
    logic rx_acq_o, rx_sym_o, rx_valid_o;
    logic [1:0] rx_data_o;
    int miscompares = 0;
    int comparisons = 0;
    int cyc = 0;
    int took, if_nz, if_bad, rs;
    int sym_t[$];
    logic [1:0] rx_w[$];

    dsss_core dsss_core_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .chip_div_i(chip_div_i),
        .acq_len_i(acq_len_i), .data_len_i(data_len_i), .acq_code_i(acq_code_i), .data_code_i(data_code_i),
        .qpsk_mode_i(qpsk_mode_i), .overlay_en_i(overlay_en_i), .ext_mod_i(ext_mod_i), .tx_start_i(tx_start_i),
        .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .tx_active_o(tx_active_o),
        .tx_sym_o(tx_sym_o), .tx_chip_i_o(tx_chip_i_o), .tx_chip_q_o(tx_chip_q_o), .tx_if_o(tx_if_o),
        .rx_i_i(rx_i_i), .rx_q_i(rx_q_i), .rx_thresh_i(rx_thresh_i), .rx_restart_i(rx_restart_i),
        .rx_acq_o(rx_acq_o), .rx_sym_o(rx_sym_o), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o));
    dsss_link_model dsss_link_model_inst (.sys_clk_i(sys_clk_i), .active_i(tx_active_o),
        .chip_i_i(tx_chip_i_o), .chip_q_i(tx_chip_q_o), .rx_i_o(rx_i_i), .rx_q_o(rx_q_i));

    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // --------------------------------
    // monitors
    // --------------------------------
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (rx_valid_o === 1'b1) rx_w.push_back(rx_data_o);
        if (tx_sym_o === 1'b1) sym_t.push_back(cyc);
        if (rx_sym_o === 1'b1 && rx_valid_o !== 1'b1) rs <= rs + 1;
        if (tx_if_o !== 8'h00) begin
            if_nz <= if_nz + 1;
            if (tx_if_o !== 8'h7F && tx_if_o !== 8'h81) if_bad <= if_bad + 1;
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cfg(input logic [7:0] dv, input logic [6:0] al, input logic q, input logic ov, input logic ex);
        chip_div_i <= dv;
        acq_len_i <= al;
        qpsk_mode_i <= q;
        overlay_en_i <= ov;
        ext_mod_i <= ex;
        rx_thresh_i <= {al[6:0], 1'b0} - 8'h02;
        @(posedge sys_clk_i);
    endtask

    task automatic load(input int want, input int tries);
        took = 0;
        for (int k = 0; k < tries && took < want; k++) begin
            tx_data_i <= 2'(took * 3 + 1);
            tx_valid_i <= 1'b1;
            @(negedge sys_clk_i);
            if (tx_ready_o === 1'b1) took++;
            @(posedge sys_clk_i);
        end
        tx_valid_i <= 1'b0;
    endtask

    task automatic burst(input int n, input int dl, input int dv);
        int g;
        logic [1:0] e;
        rx_w.delete();
        sym_t.delete();
        if_nz = 0;
        if_bad = 0;
        rs = 0;
        tx_start_i <= 1'b1;
        @(posedge sys_clk_i);
        tx_start_i <= 1'b0;
        @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        check("active", 16'(tx_active_o), 16'h0001);
        for (g = 0; g < 20000 && tx_active_o === 1'b1; g++) @(posedge sys_clk_i);
        repeat (3 * dl * dv) @(posedge sys_clk_i);
        check("symbols", 16'(sym_t.size()), 16'(n + 1));
        for (int k = 1; k < sym_t.size(); k++) check("gap", 16'(sym_t[k] - sym_t[k-1]), 16'(dl * dv));
        check("rx count ok", 16'(rx_w.size() >= n), 16'h0001);
        check("rx preamble strobe", 16'(rs), 16'h0001);
        for (int k = 0; k < n && k < rx_w.size(); k++) begin
            e = 2'(k * 3 + 1);
            if (qpsk_mode_i) check("rx word", 16'(rx_w[k]), 16'(e));
            else check("rx bit", 16'(rx_w[k][0]), 16'(e[0]));
        end
        check("if bad", 16'(if_bad), 16'h0000);
        check("if on", 16'(if_nz > 0), 16'(!ext_mod_i));
        @(negedge sys_clk_i);
        check("locked", 16'(rx_acq_o), 16'h0001);
        @(posedge sys_clk_i);
        rx_restart_i <= 1'b1;
        @(posedge sys_clk_i);
        rx_restart_i <= 1'b0;
        @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        check("unlocked", 16'(rx_acq_o), 16'h0000);
        @(posedge sys_clk_i);
    endtask

    task automatic t_reset;
        @(negedge sys_clk_i);
        check("ready in reset", 16'(tx_ready_o), 16'h0000);
        check("acq in reset", 16'(rx_acq_o), 16'h0000);
        @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        check("ready after reset", 16'(tx_ready_o), 16'h0001);
        check("idle after reset", 16'(tx_active_o), 16'h0000);
        @(posedge sys_clk_i);
        $display("test reset done");
    endtask

    task automatic t_qpsk;
        cfg(8'h04, 7'h0D, 1'b1, 1'b0, 1'b0);
        load(4, 10);
        burst(4, 11, 4);
        $display("test qpsk done");
    endtask

    task automatic t_bpsk_long;
        acq_code_i <= 64'hA5C3_96E1_3B7D_0F48;
        cfg(8'h02, 7'h40, 1'b0, 1'b1, 1'b0);
        load(3, 10);
        burst(3, 11, 4);
        $display("test bpsk long preamble done");
    endtask

    task automatic t_ext_fill;
        acq_code_i <= 64'h0000_0000_0000_0A60;
        cfg(8'h05, 7'h0D, 1'b1, 1'b1, 1'b1);
        load(18, 40);
        check("accepted", 16'(took), 16'h0011);
        @(negedge sys_clk_i);
        check("full", 16'(tx_ready_o), 16'h0000);
        @(posedge sys_clk_i);
        burst(17, 11, 5);
        $display("test external modulator full buffer done");
    endtask

    task automatic close_out;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #200000;
        miscompares++;
        close_out();
    end

    initial begin
        @(posedge sys_clk_i);
        t_reset();
        t_qpsk();
        t_bpsk_long();
        t_ext_fill();
        close_out();
    end
endmodule
